// ===== design/relay_channel_mode_control.sv
// Per-channel mode, pad selection, standby and reset control
`timescale 1ns/1ps
`include "relay_mode_regs.svh"

module relay_channel_mode_control #(
  parameter int CHANNELS = 8,
  parameter int PADS = 4,
  parameter int STANDBY_EXIT_CYCLES = `STANDBY_EXIT_CYCLES,
  parameter int RESET_WAKE_CYCLES = `RESET_WAKE_CYCLES
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic reset_pad_n,
  input wire logic [PADS-1:0] control_pad,
  input wire logic cs_n,
  input wire logic spi_so_data,
  input wire logic mode_write,
  input wire logic [2*CHANNELS-1:0] mode_wdata,
  input wire logic select_write,
  input wire logic [2*CHANNELS-1:0] pad_source_select,
  input wire logic [CHANNELS-1:0] clamp_active,
  output logic [CHANNELS-1:0] stage_on,
  output logic [CHANNELS-1:0] stage_clear,
  output logic [2*CHANNELS-1:0] mode_status,
  output logic standby,
  output logic ready,
  output logic so_out,
  output logic so_oe_n
);

  // ***************************************************************
  // Parameters and state
  // ***************************************************************
  // Counter width; holds the long standby exit count at the full rate
  localparam int CW = 32;

  // Refuse sizes the logic cannot serve: select fields are two bits wide
  if (CHANNELS < 1 || PADS != 4 ||
      STANDBY_EXIT_CYCLES < 1 || RESET_WAKE_CYCLES < 1) begin : g_bad_params
    $error("relay_channel_mode_control: unsupported parameters");
  end

  // All state of the block in one record
  // Pins from outside the clock domain pass two flops before any logic
  typedef struct packed {
    logic [1:0] rst_sync;
    logic [1:0] cs_sync; // Chip select synchroniser, idles deselected
    logic pad_reset; // Synced reset pad seen low one edge ago
    logic [PADS-1:0] pad_meta;
    logic [PADS-1:0] pad_sync;
    logic [CHANNELS-1:0] clamp_meta;
    logic [CHANNELS-1:0] clamp_sync;
    logic [2*CHANNELS-1:0] mode;
    logic [2*CHANNELS-1:0] sel;
    logic [CHANNELS-1:0] on;
    logic [CHANNELS-1:0] clr;
    logic [CHANNELS-1:0] clamp_lock;
    relay_mode_pkg::dev_state_e state;
    logic [CW-1:0] count;
    logic so_out;
    logic so_oe_n;
  } state_s;

  state_s cur;
  state_s next_cur;

  // ***************************************************************
  // Channel decoding
  // ***************************************************************
  // Decode the level that drives one channel in its current mode
  // Clear, OFF and any unknown code give a low drive
  function automatic logic chan_drive(input logic [1:0] m, input logic [1:0] s,
                                      input logic [PADS-1:0] pads);
    case (m)
      `MODE_ON: chan_drive = 1'b1;
      `MODE_INPUT: chan_drive = pads[s]; // [RULE_05] [RULE_09] [RULE_11]
      default: chan_drive = 1'b0;
    endcase
  endfunction

  // ***************************************************************
  // Next state
  // ***************************************************************
  // Next-state computation for the whole block
  always_comb begin
    logic all_clear;
    logic drive;
    next_cur = cur;
    all_clear = 1'b1;
    drive = 1'b0;
    // Two-flop synchronisers for pins
    next_cur.rst_sync = {cur.rst_sync[0], reset_pad_n};
    next_cur.cs_sync = {cur.cs_sync[0], cs_n};
    // Delayed copy lines standby up with the edge at which the stages drop
    next_cur.pad_reset = !cur.rst_sync[1]; // [RULE_03]
    next_cur.pad_meta = control_pad;
    next_cur.pad_sync = cur.pad_meta;
    next_cur.clamp_meta = clamp_active;
    next_cur.clamp_sync = cur.clamp_meta;
    // Host writes land at once; a low reset pad overrides them below
    if (select_write) begin
      next_cur.sel = pad_source_select; // [RULE_05]
    end
    if (mode_write) begin
      next_cur.mode = mode_wdata; // [RULE_10] [RULE_16]
    end
    for (int i = 0; i < CHANNELS; i++) begin
      if (cur.mode[2*i +: 2] != `MODE_CLEAR) begin
        all_clear = 1'b0;
      end
      drive = chan_drive(cur.mode[2*i +: 2], cur.sel[2*i +: 2], cur.pad_sync);
      // Clamping blocks switch-on until the clamp has gone and a re-enable arrives
      if (cur.clamp_sync[i]) begin
        next_cur.clamp_lock[i] = 1'b1; // [RULE_07]
      end else if (!drive) begin
        next_cur.clamp_lock[i] = 1'b0; // [RULE_07]
      end
      next_cur.on[i] = drive && !cur.clamp_lock[i] && !cur.clamp_sync[i]
                       && cur.state == relay_mode_pkg::st_run; // [RULE_10] [RULE_07]
      next_cur.clr[i] = (cur.mode[2*i +: 2] == `MODE_CLEAR)
                        || cur.state == relay_mode_pkg::st_reset_wake;
    end
    // Device-level state sequencing
    // Stages stay off in every state but run; counts restart on each entry
    case (cur.state)
      relay_mode_pkg::st_reset_wake: begin
        next_cur.on = '0;
        if (cur.count >= CW'(RESET_WAKE_CYCLES - 1)) begin
          next_cur.state = relay_mode_pkg::st_run; // [RULE_14]
          next_cur.count = '0;
        end else begin
          next_cur.count = cur.count + 1'b1;
        end
      end
      relay_mode_pkg::st_run: begin
        if (all_clear) begin
          next_cur.state = relay_mode_pkg::st_standby; // [RULE_04]
          next_cur.sel = '0;
          next_cur.on = '0;
        end
      end
      relay_mode_pkg::st_standby: begin
        next_cur.on = '0;
        if (!all_clear) begin
          next_cur.state = relay_mode_pkg::st_standby_exit; // [RULE_08]
          next_cur.count = '0;
        end
      end
      relay_mode_pkg::st_standby_exit: begin
        next_cur.on = '0;
        if (all_clear) begin
          next_cur.state = relay_mode_pkg::st_standby;
        end else if (cur.count >= CW'(STANDBY_EXIT_CYCLES - 1)) begin
          next_cur.state = relay_mode_pkg::st_run; // [RULE_12]
          next_cur.count = '0;
        end else begin
          next_cur.count = cur.count + 1'b1;
        end
      end
      default: begin
        next_cur.state = relay_mode_pkg::st_reset_wake;
      end
    endcase
    // Serial output released while deselected or in reset
    // Chip select is a pin, so it is read only after its synchroniser
    next_cur.so_oe_n = cur.cs_sync[1] || !cur.rst_sync[1]; // [RULE_15]
    next_cur.so_out = spi_so_data && !cur.cs_sync[1] && cur.rst_sync[1];
    // Reset pad low forces every control register to default; the pin synchronisers keep sampling
    // It also restarts the wake count, so the host waits again after release
    if (!cur.rst_sync[1]) begin
      next_cur.mode = {CHANNELS{`MODE_RESET_VALUE}}; // [RULE_03] [RULE_01]
      next_cur.sel = '0;
      next_cur.on = '0; // [RULE_06]
      next_cur.clr = '1; // [RULE_06]
      next_cur.clamp_lock = '0;
      next_cur.state = relay_mode_pkg::st_reset_wake;
      next_cur.count = '0;
    end
  end

  // ***************************************************************
  // Registers
  // ***************************************************************
  // State register with synchronous power-on reset
  // Reset pad chain starts low, so the wake count follows power-on too
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      cur.rst_sync <= 2'h0;
      cur.cs_sync <= 2'h3; // Serial pin starts released
      cur.pad_reset <= 1'b1;
      cur.pad_meta <= '0;
      cur.pad_sync <= '0;
      cur.clamp_meta <= '0;
      cur.clamp_sync <= '0;
      cur.mode <= {CHANNELS{`MODE_RESET_VALUE}}; // [RULE_01]
      cur.sel <= '0;
      cur.on <= '0; // [RULE_06]
      cur.clr <= '1; // [RULE_06]
      cur.clamp_lock <= '0;
      cur.state <= relay_mode_pkg::st_reset_wake;
      cur.count <= '0;
      cur.so_out <= 1'b0;
      cur.so_oe_n <= 1'b1;
    end else begin
      cur <= next_cur;
    end
  end

  // ***************************************************************
  // Outputs
  // ***************************************************************
  // Outputs from registers; ready only decodes state, standby also takes the delayed reset pad flag
  assign stage_on = cur.on;
  assign stage_clear = cur.clr;
  assign mode_status = cur.mode;
  assign standby = (cur.state == relay_mode_pkg::st_standby) || cur.pad_reset; // [RULE_03]
  assign ready = (cur.state == relay_mode_pkg::st_run); // [RULE_14]
  assign so_out = cur.so_out;
  assign so_oe_n = cur.so_oe_n;

endmodule

// ===== design/relay_mode_pkg.sv
// Types for the relay channel mode control block
package relay_mode_pkg;

  typedef enum logic [1:0] {
    clear_state = 2'b00,
    mode_off = 2'b01,
    mode_on = 2'b10,
    mode_input = 2'b11
  } chan_mode_e;

  typedef enum logic [1:0] {
    st_reset_wake = 2'b00,
    st_run = 2'b01,
    st_standby = 2'b10,
    st_standby_exit = 2'b11
  } dev_state_e;

endpackage

// ===== design/relay_mode_regs.svh
// Constants for the relay channel mode control block
// What the document requires of this block and its host
// [RULE_01] Supply start or reset sets channels OFF
// [RULE_02] Host programs Clear once after power-up
// [RULE_03] Reset pad low defaults all, quiet state
// [RULE_04] All eight channels Clear enters standby
// [RULE_05] Per-channel field picks one of four pads
// [RULE_06] During reset output stages held Clear
// [RULE_07] Re-enable accepted only after clamping ends
// [RULE_08] Host leaves standby: OFF, wait, ON
// [RULE_09] Input mode: pad high ON, low OFF
// [RULE_10] Stage driven by switch bit or pad
// [RULE_11] Open control pad reads low, channel off
// [RULE_12] Standby exit delay at most 200 ms
// [RULE_13] Host holds reset pad low 50 us
// [RULE_14] Ready within 200 us after reset release
// [RULE_15] Serial output tristate on CS high/reset
// [RULE_16] Each channel holds Clear, OFF, ON, Input
`ifndef RELAY_MODE_REGS_SVH
`define RELAY_MODE_REGS_SVH

// ***************************************************************
// Timing figures
// ***************************************************************
`define CLK_PERIOD_NS 40
`define STANDBY_EXIT_DELAY_MS 200
`define STANDBY_EXIT_CYCLES ((`STANDBY_EXIT_DELAY_MS * 1000000) / `CLK_PERIOD_NS)
`define RESET_WAKE_US 200
`define RESET_WAKE_CYCLES ((`RESET_WAKE_US * 1000) / `CLK_PERIOD_NS)
`define RESET_HOLD_US 50

// ***************************************************************
// Mode encodings and field layout
// ***************************************************************
`define MODE_CLEAR 2'h0
`define MODE_OFF 2'h1
`define MODE_ON 2'h2
`define MODE_INPUT 2'h3
`define MODE_RESET_VALUE 2'h1
`define MODE_WIDTH 2
`define SEL_WIDTH 2

`endif

// ===== tb/host_pad_model.sv
// Host side drivers of the control and reset pads
`timescale 1ns/1ps
module host_pad_model (
  input wire logic [3:0] pad_val,
  input wire logic [3:0] pad_en,
  input wire logic rst_en,
  output logic [3:0] control_pad,
  output logic reset_pad_n
);
  // ****
  // Released pads fall to the pull-down level
  // ****
  assign control_pad = pad_val & pad_en;
  assign reset_pad_n = rst_en;
endmodule

// ===== tb/relay_channel_mode_control_tb.sv
// Self-checking bench for the relay channel mode control block
`timescale 1ns/1ps
`include "relay_mode_regs.svh"
module relay_channel_mode_control_tb;
  logic ref_clk = 0, resetn = 0, cs_n = 1, mode_write = 0, select_write = 0, rst_en = 1;
  logic [15:0] mode_wdata = 16'h0000, sel = 16'h0000, mode_status;
  logic [7:0] clamp_active = 8'h00, stage_on, stage_clear;
  logic [3:0] pad_val = 4'h0, pad_en = 4'h0, control_pad;
  logic reset_pad_n, standby, ready, so_out, so_oe_n;
  logic so_data = 0;
  int failures = 0, n_checks = 0, cycles = 0;

  host_pad_model u_host (.pad_val, .pad_en, .rst_en, .control_pad, .reset_pad_n);
  relay_channel_mode_control #(.STANDBY_EXIT_CYCLES(10), .RESET_WAKE_CYCLES(8)) u_dut (
    .ref_clk, .resetn, .reset_pad_n, .control_pad, .cs_n, .spi_so_data(so_data), .mode_write,
    .mode_wdata, .select_write, .pad_source_select(sel), .clamp_active, .stage_on,
    .stage_clear, .mode_status, .standby, .ready, .so_out, .so_oe_n);

  // ****
  // Clock, hang guard and tasks
  // ****
  initial begin
    forever #20 ref_clk = ~ref_clk;
  end
  // Cut a hung run short
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      failures = failures + 1;
      print_verdict();
    end
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Load the mode bus, or the pad select bus when s is set
  task automatic wr(input logic s, input logic [15:0] d);
    @(negedge ref_clk);
    if (s) begin
      sel = d;
      select_write = 1;
    end else begin
      mode_wdata = d;
      mode_write = 1;
    end
    @(negedge ref_clk);
    select_write = 0;
    mode_write = 0;
    repeat (2) @(negedge ref_clk);
  endtask
  task automatic wait_ready();
    for (int i = 0; i < 60 && ready !== 1'b1; i++) @(negedge ref_clk);
    chk("ready", 1, ready);
  endtask
  task automatic print_verdict();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ****
  // Main sequence
  // ****
  initial begin
    repeat (4) @(negedge ref_clk);
    resetn = 1;
    wait_ready();
    chk("mode_status", 16'h5555, mode_status);
    chk("stage_on", 16'h00, stage_on);
    wr(0, 16'h0000);
    chk("standby", 1, standby);
    chk("stage_clear", 16'hFF, stage_clear);
    wr(0, 16'h5555);
    chk("ready", 0, ready);
    wait_ready();
    wr(0, 16'h5556);
    chk("stage_on", 16'h01, stage_on);
    chk("stage_clear", 16'h00, stage_clear);
    wr(1, 16'hE4E4);
    wr(0, 16'hFFFF);
    pad_en = 4'hF;
    for (int k = 0; k < 4; k++) begin
      pad_val = 4'h1 << k;
      repeat (5) @(negedge ref_clk);
      chk("stage_on", 16'h11 << k, stage_on);
    end
    pad_en = 4'h0;
    repeat (5) @(negedge ref_clk);
    chk("stage_on", 0, stage_on);
    wr(0, 16'h5556);
    clamp_active = 8'h01;
    repeat (5) @(negedge ref_clk);
    chk("stage_on", 0, stage_on);
    clamp_active = 8'h00;
    repeat (5) @(negedge ref_clk);
    chk("stage_on", 0, stage_on);
    wr(0, 16'h5555);
    wr(0, 16'h5556);
    chk("stage_on", 1, stage_on);
    cs_n = 0;
    so_data = 1;
    repeat (4) @(negedge ref_clk);
    chk("so_oe_n", 0, so_oe_n);
    chk("so_out", 1, so_out);
    rst_en = 0;
    repeat ((`RESET_HOLD_US * 1000) / `CLK_PERIOD_NS) @(negedge ref_clk);
    chk("mode_status", 16'h5555, mode_status);
    chk("stage_clear", 16'hFF, stage_clear);
    chk("stage_on", 0, stage_on);
    chk("standby", 1, standby);
    chk("so_oe_n", 1, so_oe_n);
    chk("so_out", 0, so_out);
    rst_en = 1;
    wait_ready();
    chk("mode_status", 16'h5555, mode_status);
    print_verdict();
  end
endmodule

// ===== tb/relay_mode_properties.sv
// Port assertions for the relay channel mode control block
`timescale 1ns/1ps
module relay_mode_props (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic reset_pad_n,
  input wire logic cs_n,
  input wire logic mode_write,
  input wire logic [15:0] mode_wdata,
  input wire logic [15:0] mode_status,
  input wire logic [7:0] stage_on,
  input wire logic [7:0] stage_clear,
  input wire logic standby,
  input wire logic ready,
  input wire logic so_oe_n
);
  // ****
  // Checks
  // ****
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  a_pad_defaults: assert property (!reset_pad_n [*4] |-> stage_clear == 8'hFF)
    else $error("stages not held clear in pad reset");
  a_pad_modes_off: assert property (
    !reset_pad_n [*4] |-> mode_status == 16'h5555)
    else $error("modes not OFF in pad reset");
  a_so_tristate: assert property ((cs_n [*4]) or (!reset_pad_n [*4]) |-> so_oe_n)
    else $error("serial out driven while idle");
  a_all_clear_standby: assert property (ready && mode_status == 16'h0000 |=> standby)
    else $error("no standby with all channels clear");
  a_standby_quiet: assert property (standby |-> stage_on == 8'h00)
    else $error("stage on in standby");
  a_idle_off: assert property (!ready && !$past(ready) |-> stage_on == 8'h00)
    else $error("stage on outside run");
  a_mode_load: assert property (
    reset_pad_n [*4] ##0 mode_write |=> mode_status == $past(mode_wdata))
    else $error("mode write not loaded");
  a_clear_drive: assert property (
    mode_status[1:0] == 2'h0 |=> stage_clear[0] && !stage_on[0])
    else $error("clear mode not applied");
  a_wake_wait: assert property ($rose(reset_pad_n) |-> !ready [*8])
    else $error("ready too early after pad reset");
endmodule

bind relay_channel_mode_control relay_mode_props u_props (.ref_clk, .resetn, .reset_pad_n,
  .cs_n, .mode_write, .mode_wdata, .mode_status, .stage_on, .stage_clear, .standby, .ready,
  .so_oe_n);
